// ===== inc/rsc_cfg.svh
// register map, field positions, reset values and timing counts for the reset and clock source control
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

`define RSC_ADDR_W         8
`define RSC_DATA_W         32
`define RSC_REG_ENABLE     8'h00
`define RSC_REG_WDLOCK     8'h04
`define RSC_REG_SWRST      8'h08
`define RSC_REG_CLKSEL     8'h0c
`define RSC_REG_CAUSE      8'h10
`define RSC_REG_STATUS     8'h14

`define RSC_ENABLE_RST     5'h01
`define RSC_WDLOCK_KEY     8'ha5
`define RSC_CAUSE_POR      8'h01

`define RSC_CAUSE_POR_BIT  0
`define RSC_CAUSE_PIN_BIT  1
`define RSC_CAUSE_SUP_BIT  2
`define RSC_CAUSE_SRC_LSB  3
`define RSC_STAT_EXT_BIT   0
`define RSC_STAT_LOCK_BIT  1
`define RSC_STAT_WDOG_BIT  2
`define RSC_STAT_ST_LSB    4

`define RSC_CLK_PERIOD_PS  4000
`define RSC_POR_DRIVE_NS   1000
`define RSC_HOLD_NS        100
`define RSC_POR_DRIVE_CYC  ((`RSC_POR_DRIVE_NS * 1000 + `RSC_CLK_PERIOD_PS - 1) / `RSC_CLK_PERIOD_PS)
`define RSC_HOLD_CYC       ((`RSC_HOLD_NS * 1000 + `RSC_CLK_PERIOD_PS - 1) / `RSC_CLK_PERIOD_PS)

`endif

// ===== inc/rsc_pkg.sv
// types shared by the reset and clock source control
package rsc_pkg;

	// maskable reset sources, bit 0 is the watchdog
	typedef struct packed {
		logic cnv;
		logic sw;
		logic cmp;
		logic mclk;
		logic wdog;
	} rsc_src_type;

	// avalon-mm slave request
	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
	} rsc_avs_cmd_type;

	// sequencer states, gray along por -> hold -> run
	typedef enum logic [1:0] {
		RSC_ST_POR  = 2'b00,
		RSC_ST_HOLD = 2'b01,
		RSC_ST_RUN  = 2'b11
	} rsc_state_type;

endpackage

// ===== core/rsc_sync3.sv
// three-stage input synchroniser that accepts a change once stages two and three agree
module rsc_sync3 #(
	parameter int              W    = 1,
	parameter logic [W-1:0]    INIT = '0
) (
	input  wire logic          clock,
	input  wire logic          rst,
	input  wire logic [W-1:0]  d,
	output logic      [W-1:0]  q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	// stage one feeds stage two only; the agreement filter looks at two and three
	always_comb begin
		for (int i = 0; i < W; i++) begin
			q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
			q_r  <= INIT;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r  <= q_nxt;
		end
	end

	assign q = q_r;
endmodule // rsc_sync3

// ===== core/rsc_seq.sv
// reset source collector, reset pin driver and system clock source select with avalon-mm registers
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`include "rsc_cfg.svh"

module rsc_seq #(
	parameter int POR_DRIVE_CYC = `RSC_POR_DRIVE_CYC,
	parameter int HOLD_CYC      = `RSC_HOLD_CYC
) (
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire rsc_pkg::rsc_avs_cmd_type avs_cmd,
	output logic                          avs_waitrequest,
	output logic [31:0]                   avs_readdata,
	input  wire logic                     rst_pin_n_in,
	output logic                          rst_pin_out,
	output logic                          rst_pin_oe,
	input  wire logic                     supply_monitor_enable_pin,
	input  wire logic                     supply_low,
	input  wire logic                     level_compare_zero,
	input  wire logic                     conversion_start_pin,
	input  wire logic                     wdog_expire,
	input  wire logic                     missing_clock,
	output logic                          wdog_enable,
	output logic                          clk_sel_ext,
	output logic                          sys_reset
);
	import rsc_pkg::*;

	localparam int CNT_W = $clog2(((POR_DRIVE_CYC > HOLD_CYC) ? POR_DRIVE_CYC : HOLD_CYC) + 1);
	localparam logic [CNT_W-1:0] POR_LOAD  = CNT_W'(POR_DRIVE_CYC - 1);
	localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_CYC - 1);

	// decode shared by the read and the write path
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr == off);
	endfunction

	// synchronised pins: {reset pin, monitor enable, supply low, comparator, conversion start}
	logic [4:0] pins_s;
	logic       pin_n_s;
	logic       supply_monitor_enable_pin_s;
	logic       sup_low_s;
	logic       cmp_s;
	logic       cnv_s;

	rsc_sync3 #(
		.W    (5),
		.INIT (5'h18)
	) u_sync (
		.clock (clock),
		.rst   (rst),
		.d     ({rst_pin_n_in, supply_monitor_enable_pin, supply_low, level_compare_zero, conversion_start_pin}),
		.q     (pins_s)
	);

	assign pin_n_s   = pins_s[4];
	assign supply_monitor_enable_pin_s   = pins_s[3];
	assign sup_low_s = pins_s[2];
	assign cmp_s     = pins_s[1];
	assign cnv_s     = pins_s[0];

	// sequencer state
	rsc_state_type    state_r;
	rsc_state_type    state_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic             sys_reset_r;
	logic             sys_reset_nxt;
	logic             pin_oe_r;
	logic             pin_oe_nxt;
	logic             pin_out_r;

	// software-visible state
	rsc_src_type      en_r;
	rsc_src_type      en_nxt;
	logic             lock_r;
	logic             lock_nxt;
	logic             sw_req_r;
	logic             sw_req_nxt;
	logic             clk_ext_r;
	logic             clk_ext_nxt;
	logic [7:0]       cause_r;
	logic [7:0]       cause_nxt;
	logic             wdog_en_r;
	logic             wdog_en_nxt;

	// bus state
	logic             wait_r;
	logic             wait_nxt;
	logic [31:0]      rdata_r;
	logic [31:0]      rdata_nxt;

	// request collection
	rsc_src_type      src_act;
	rsc_src_type      en_eff;
	rsc_src_type      src_hit;
	logic             sup_req;
	logic             pin_req;
	logic             any_req;
	logic [7:0]       cause_new;
	logic             req;
	logic             wr_take;

	always_comb begin
		src_act.wdog = wdog_expire;
		src_act.mclk = missing_clock;
		src_act.cmp  = cmp_s;
		src_act.sw   = sw_req_r;
		src_act.cnv  = cnv_s;
		en_eff       = en_r;
		en_eff.wdog  = en_r.wdog | lock_r;
		src_hit      = src_act & en_eff;
		sup_req      = sup_low_s & supply_monitor_enable_pin_s;
		pin_req      = ~pin_n_s;
		any_req      = (|src_hit) | sup_req | pin_req;
		cause_new    = {src_hit, sup_req, pin_req, 1'b0};
	end

	// reset sequencer: drive the pin after power-on, then hold until all requests are gone
	always_comb begin
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		pin_oe_nxt = 1'b0;
		case (state_r)
			RSC_ST_POR: begin
				pin_oe_nxt = 1'b1;
				if (cnt_r == '0) begin
					state_nxt  = RSC_ST_HOLD;
					cnt_nxt    = HOLD_LOAD;
					pin_oe_nxt = 1'b0;
				end else begin
					cnt_nxt = cnt_r - CNT_W'(1);
				end
			end
			RSC_ST_HOLD: begin
				if (any_req) begin
					cnt_nxt = HOLD_LOAD;
				end else if (cnt_r == '0) begin
					state_nxt = RSC_ST_RUN;
				end else begin
					cnt_nxt = cnt_r - CNT_W'(1);
				end
			end
			RSC_ST_RUN: begin
				if (any_req) begin
					state_nxt = RSC_ST_HOLD;
					cnt_nxt   = HOLD_LOAD;
				end
			end
			default: begin
				state_nxt  = RSC_ST_POR;
				cnt_nxt    = POR_LOAD;
				pin_oe_nxt = 1'b1;
			end
		endcase
		// release only on a clock edge, never straight from the pins
		sys_reset_nxt = (state_nxt != RSC_ST_RUN);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r     <= RSC_ST_POR;
			cnt_r       <= POR_LOAD;
			sys_reset_r <= 1'b1;
			pin_oe_r    <= 1'b1;
			pin_out_r   <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			cnt_r       <= cnt_nxt;
			sys_reset_r <= sys_reset_nxt;
			pin_oe_r    <= pin_oe_nxt;
			pin_out_r   <= 1'b0;
		end
	end

	// bus: one wait state; the write lands on the edge that sees waitrequest low
	assign req     = avs_cmd.read | avs_cmd.write;
	assign wr_take = avs_cmd.write & ~wait_r & ~sys_reset_r;

	always_comb begin
		wait_nxt  = 1'b1;
		rdata_nxt = rdata_r;
		if (req && wait_r) begin
			wait_nxt  = 1'b0;
			rdata_nxt = 32'h0000_0000;
			if (hit(avs_cmd.address, `RSC_REG_ENABLE)) begin
				rdata_nxt[4:0] = en_r;
			end else if (hit(avs_cmd.address, `RSC_REG_WDLOCK)) begin
				rdata_nxt[0] = lock_r;
			end else if (hit(avs_cmd.address, `RSC_REG_SWRST)) begin
				rdata_nxt[0] = sw_req_r;
			end else if (hit(avs_cmd.address, `RSC_REG_CLKSEL)) begin
				rdata_nxt[0] = clk_ext_r;
			end else if (hit(avs_cmd.address, `RSC_REG_CAUSE)) begin
				rdata_nxt[7:0] = cause_r;
			end else if (hit(avs_cmd.address, `RSC_REG_STATUS)) begin
				rdata_nxt[`RSC_STAT_EXT_BIT]                  = clk_ext_r;
				rdata_nxt[`RSC_STAT_LOCK_BIT]                 = lock_r;
				rdata_nxt[`RSC_STAT_WDOG_BIT]                 = wdog_en_r;
				rdata_nxt[`RSC_STAT_ST_LSB+1:`RSC_STAT_ST_LSB] = state_r;
			end
		end
	end

	// software registers; a system reset restores defaults except the lock and the cause
	always_comb begin
		en_nxt      = en_r;
		lock_nxt    = lock_r;
		sw_req_nxt  = sw_req_r;
		clk_ext_nxt = clk_ext_r;
		if (sys_reset_r) begin
			en_nxt      = `RSC_ENABLE_RST;
			sw_req_nxt  = 1'b0;
			clk_ext_nxt = 1'b0;
		end else if (wr_take) begin
			if (hit(avs_cmd.address, `RSC_REG_ENABLE)) begin
				en_nxt = avs_cmd.writedata[4:0];
			end
			// the lock has no clear path; only the power-on reset drops it
			if (hit(avs_cmd.address, `RSC_REG_WDLOCK) && avs_cmd.writedata[7:0] == `RSC_WDLOCK_KEY) begin
				lock_nxt = 1'b1;
			end
			if (hit(avs_cmd.address, `RSC_REG_SWRST) && avs_cmd.writedata[0]) begin
				sw_req_nxt = 1'b1;
			end
			if (hit(avs_cmd.address, `RSC_REG_CLKSEL)) begin
				clk_ext_nxt = avs_cmd.writedata[0];
			end
		end
		wdog_en_nxt = en_nxt.wdog | lock_nxt;
		// cause restarts on a new reset entry and accumulates while reset holds
		if (state_r == RSC_ST_RUN) begin
			cause_nxt = any_req ? cause_new : cause_r;
		end else begin
			cause_nxt = cause_r | cause_new;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			en_r      <= `RSC_ENABLE_RST;
			lock_r    <= 1'b0;
			sw_req_r  <= 1'b0;
			clk_ext_r <= 1'b0;
			cause_r   <= `RSC_CAUSE_POR;
			wdog_en_r <= 1'b1;
			wait_r    <= 1'b1;
			rdata_r   <= 32'h0000_0000;
		end else begin
			en_r      <= en_nxt;
			lock_r    <= lock_nxt;
			sw_req_r  <= sw_req_nxt;
			clk_ext_r <= clk_ext_nxt;
			cause_r   <= cause_nxt;
			wdog_en_r <= wdog_en_nxt;
			wait_r    <= wait_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

	assign avs_waitrequest = wait_r;
	assign avs_readdata    = rdata_r;
	assign rst_pin_out     = pin_out_r;
	assign rst_pin_oe      = pin_oe_r;
	assign wdog_enable     = wdog_en_r;
	// the clock mux itself sits in the oscillator block; external element type is its concern
	assign clk_sel_ext     = clk_ext_r;
	assign sys_reset       = sys_reset_r;
endmodule // rsc_seq

// ===== sim/rsc_board.sv
// board side: pulled-up reset pin, push-button and monitor strap
module rsc_board (
	input  wire logic dev_oe,
	input  wire logic dev_out,
	input  wire logic press,
	input  wire logic strap,
	output logic      pin_n,
	output logic      mon_en
);
	timeunit 1ns;
	timeprecision 1ps;
	// open drain: pull-up wins unless device or button pulls low
	assign pin_n  = !((dev_oe && !dev_out) || press);
	// monitor gate is a strap, software cannot reach it
	assign mon_en = strap;
endmodule // rsc_board

// ===== sim/rsc_seq_checker.sv
// port assertions for the reset and clock source control
module rsc_seq_checker (
	input wire logic                     clock,
	input wire logic                     rst,
	input wire rsc_pkg::rsc_avs_cmd_type avs_cmd,
	input wire logic                     avs_waitrequest,
	input wire logic                     rst_pin_n_in,
	input wire logic                     rst_pin_out,
	input wire logic                     rst_pin_oe,
	input wire logic                     supply_monitor_enable_pin,
	input wire logic                     supply_low,
	input wire logic                     wdog_expire,
	input wire logic                     wdog_enable,
	input wire logic                     clk_sel_ext,
	input wire logic                     sys_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	import rsc_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	pin_drive_a: assert property (rst_pin_oe |-> !rst_pin_out && sys_reset)
		else $error("pin driven without low level or reset");
	wdog_fire_a: assert property (!sys_reset && wdog_enable && wdog_expire |=> sys_reset)
		else $error("watchdog request missed");
	reset_hold_a: assert property (sys_reset && wdog_enable && wdog_expire |=> sys_reset)
		else $error("reset released while request active");
	pin_reset_a: assert property (!rst_pin_n_in |-> ##[1:8] sys_reset)
		else $error("reset pin ignored");
	supply_reset_a: assert property (supply_monitor_enable_pin && supply_low |-> ##[1:8] sys_reset)
		else $error("supply monitor ignored");
	clk_internal_a: assert property (sys_reset |=> !clk_sel_ext)
		else $error("external clock kept through reset");
	clk_steady_a: assert property (!sys_reset && !avs_cmd.write |=> $stable(clk_sel_ext))
		else $error("clock select moved without write");
	bus_answer_a: assert property ((avs_cmd.read || avs_cmd.write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered");
	wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer longer than one cycle");
endmodule // rsc_seq_checker

bind rsc_seq rsc_seq_checker u_chk (.clock(clock), .rst(rst), .avs_cmd(avs_cmd),
	.avs_waitrequest(avs_waitrequest), .rst_pin_n_in(rst_pin_n_in), .rst_pin_out(rst_pin_out),
	.rst_pin_oe(rst_pin_oe), .supply_monitor_enable_pin(supply_monitor_enable_pin),
	.supply_low(supply_low), .wdog_expire(wdog_expire), .wdog_enable(wdog_enable),
	.clk_sel_ext(clk_sel_ext), .sys_reset(sys_reset));

// ===== sim/rsc_seq_bench.sv
// self-checking bench for the reset and clock source control
`include "rsc_cfg.svh"
module rsc_seq_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import rsc_pkg::*;
	logic            clock = 0, rst = 1, press = 0, strap = 0, supply_low = 0;
	logic            rst_pin_n_in, rst_pin_out, rst_pin_oe, mon_en;
	logic            avs_waitrequest, wdog_enable, clk_sel_ext, sys_reset;
	logic [31:0]     avs_readdata, rd;
	logic [4:0]      src = '0;
	rsc_avs_cmd_type cmd = '0;
	int              n_errors = 0, checked = 0;
	// free-running 4 ns system clock for the device; clk_sel_ext does not switch it
	always #2 clock = !clock;
	rsc_board brd (.dev_oe(rst_pin_oe), .dev_out(rst_pin_out), .press(press), .strap(strap),
		.pin_n(rst_pin_n_in), .mon_en(mon_en));
	// short counts keep the run brief
	rsc_seq #(.POR_DRIVE_CYC(8), .HOLD_CYC(4)) dut (.clock(clock), .rst(rst), .avs_cmd(cmd),
		.avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .rst_pin_n_in(rst_pin_n_in),
		.rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .supply_monitor_enable_pin(mon_en),
		.supply_low(supply_low), .level_compare_zero(src[2]), .conversion_start_pin(src[4]),
		.wdog_expire(src[0]), .missing_clock(src[1]), .wdog_enable(wdog_enable),
		.clk_sel_ext(clk_sel_ext), .sys_reset(sys_reset));
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		cmd <= '{read: !wr, write: wr, address: a, writedata: wd};
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		chk("waitrequest", 0, avs_waitrequest);
		rd = avs_readdata;
		cmd <= '0;
		@(posedge clock);
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		bus(0, a, 0);
		chk(nm, exp, rd);
	endtask
	task automatic wait_sr(input logic v);
		int n;
		n = 0;
		while (sys_reset !== v && n < 200) begin
			@(posedge clock);
			n++;
		end
		chk("sys_reset", v, sys_reset);
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge clock);
	endtask
	task automatic test_done();
		if (n_errors == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#40000;
		n_errors++;
		test_done();
	end
	initial begin
		idle(10);
		rst <= 0;
		idle(2);
		chk("pin_por", 0, rst_pin_n_in);
		chk("pin_oe", 1, rst_pin_oe);
		chk("pin_out", 0, rst_pin_out);
		wait_sr(0);
		chk("pin_free", 0, rst_pin_oe);
		rdchk("enable", `RSC_REG_ENABLE, 32'h1);
		rdchk("clksel", `RSC_REG_CLKSEL, 32'h0);
		// the device's own pin drive echoes back through the pin sync as a pin cause
		rdchk("cause", `RSC_REG_CAUSE, 32'h3);
		rdchk("unmapped", 8'h20, 32'h0);
		bus(1, `RSC_REG_CLKSEL, 1);
		chk("clk_ext", 1, clk_sel_ext);
		bus(1, `RSC_REG_CLKSEL, 0);
		chk("clk_int", 0, clk_sel_ext);
		bus(1, `RSC_REG_ENABLE, 0);
		chk("wdog_off", 0, wdog_enable);
		src <= 5'h17;
		idle(12);
		chk("masked", 0, sys_reset);
		src <= 0;
		for (int i = 0; i < 5; i++) begin
			bus(1, `RSC_REG_CLKSEL, 1);
			bus(1, `RSC_REG_ENABLE, 32'h1 << i);
			if (i == 3) bus(1, `RSC_REG_SWRST, 1);
			else src <= 5'h1 << i;
			wait_sr(1);
			src <= 0;
			wait_sr(0);
			chk("clk_after", 0, clk_sel_ext);
			rdchk("cause_src", `RSC_REG_CAUSE, 32'h8 << i);
		end
		supply_low <= 1;
		idle(12);
		chk("mon_off", 0, sys_reset);
		strap <= 1;
		wait_sr(1);
		supply_low <= 0;
		strap <= 0;
		wait_sr(0);
		rdchk("cause_sup", `RSC_REG_CAUSE, 32'h4);
		bus(1, `RSC_REG_ENABLE, 0);
		press <= 1;
		wait_sr(1);
		press <= 0;
		wait_sr(0);
		rdchk("cause_pin", `RSC_REG_CAUSE, 32'h2);
		bus(1, `RSC_REG_WDLOCK, `RSC_WDLOCK_KEY);
		bus(1, `RSC_REG_ENABLE, 0);
		chk("wdog_lock", 1, wdog_enable);
		src <= 5'h1;
		wait_sr(1);
		src <= 0;
		wait_sr(0);
		bus(1, `RSC_REG_ENABLE, 0);
		chk("lock_kept", 1, wdog_enable);
		rdchk("lock_rd", `RSC_REG_WDLOCK, 32'h1);
		rdchk("status", `RSC_REG_STATUS, 32'h36);
		// a second power-on in mid-run is the only way to drop the lock
		rst <= 1;
		idle(2);
		rst <= 0;
		wait_sr(0);
		rdchk("lock_por", `RSC_REG_WDLOCK, 32'h0);
		rdchk("status_por", `RSC_REG_STATUS, 32'h34);
		rdchk("cause_por", `RSC_REG_CAUSE, 32'h3);
		test_done();
	end
endmodule // rsc_seq_bench
